// ===== core/ssd_map.svh
// Named constants for the stereo serial converter input block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SSD_MAP_SVH
`define SSD_MAP_SVH

// Width of one audio sample in bits.
`define SSD_SAMPLE_W        16
// Output value after reset: zero, the mid-scale code.
`define SSD_SAMPLE_RST      16'h0000
// Update delay in half bit-clock periods, counted from the select edge.
`define SSD_UPDATE_HALVES   7
// Width of the update delay counter.
`define SSD_UPD_CNT_W       2
// Default select level that marks left-channel data (0: low means left).
`define SSD_LEFT_LEVEL_DFLT 1'b0
// Number of synchroniser stages on each pin.
`define SSD_SYNC_STAGES     2

`endif

// ===== core/ssd_pkg.sv
// Types shared by the stereo serial converter input block.
// Assumes ssd_map.svh is on the include path.
`include "ssd_map.svh"

package ssd_pkg;

   typedef logic [`SSD_SAMPLE_W-1:0]  ssd_sample_t;
   typedef logic [`SSD_UPD_CNT_W-1:0] ssd_upd_cnt_t;

   // Which channel a select level marks.
   typedef enum logic {
      SSD_CH_LEFT  = 1'b0,
      SSD_CH_RIGHT = 1'b1
   } ssd_channel_t;

endpackage

// ===== core/ssd_sync.sv
// Two-stage level synchroniser for a group of pins.
// Assumes the inputs are asynchronous to clk_i; only the second stage is read.
`timescale 1ns/1ps
`include "ssd_map.svh"

module ssd_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = ce_i ? pin_i  : meta_q;
      sync_d = ce_i ? meta_q : sync_q;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;

endmodule // ssd_sync

// ===== core/ssd_input.sv
// Serial input and output-update logic of a two-channel 16-bit audio converter.
// Assumes the host bit clock is at most a quarter of mclk_i so each level is seen twice.
`timescale 1ns/1ps
`include "ssd_map.svh"

module ssd_input
   import ssd_pkg::*;
#(
   parameter logic LEFT_LEVEL = `SSD_LEFT_LEVEL_DFLT
) (
   input  wire logic  mclk_i,
   input  wire logic  reset_i,
   input  wire logic  ce_i,
   input  wire logic  bit_clk_i,
   input  wire logic  serial_data_i,
   input  wire logic  channel_select_i,
   output ssd_sample_t left_sample_o,
   output ssd_sample_t right_sample_o,
   output logic        update_o
);

   // Rising edges of the bit clock to wait after the one that sees the select change.
   localparam int unsigned UPD_EDGES = (`SSD_UPDATE_HALVES - 1) / 2;
   localparam ssd_upd_cnt_t UPD_LAST = ssd_upd_cnt_t'(UPD_EDGES - 1);

   logic [2:0] pins_s;
   logic       bclk_s;
   logic       sdata_s;
   logic       csel_s;

   ssd_sync #(
      .W (3)
   ) u_sync (
      .clk_i   (mclk_i),
      .reset_i (reset_i),
      .ce_i    (ce_i),
      .pin_i   ({bit_clk_i, serial_data_i, channel_select_i}),
      .sync_o  (pins_s)
   );

   assign bclk_s  = pins_s[2];
   assign sdata_s = pins_s[1];
   assign csel_s  = pins_s[0];

   function automatic ssd_channel_t chan_of(input logic level);
      chan_of = (level == LEFT_LEVEL) ? SSD_CH_LEFT : SSD_CH_RIGHT;
   endfunction

   // Bit-clock edge detector.
   logic         bclk_prev_q;
   logic         bclk_prev_d;
   logic         rise;

   // Receive shifter and select tracker.
   ssd_sample_t  shift_q;
   ssd_sample_t  shift_d;
   logic         csel_q;
   logic         csel_d;
   logic         seen_q;
   logic         seen_d;
   logic         csel_edge;
   logic         ends_left;
   logic         ends_right;

   // Staging registers, one per channel.
   ssd_sample_t  left_stage_q;
   ssd_sample_t  left_stage_d;
   ssd_sample_t  right_stage_q;
   ssd_sample_t  right_stage_d;

   // Update wait after a right period ends.
   logic         pend_q;
   logic         pend_d;
   ssd_upd_cnt_t cnt_q;
   ssd_upd_cnt_t cnt_d;
   logic         fire;

   // Converter outputs.
   ssd_sample_t  left_q;
   ssd_sample_t  left_d;
   ssd_sample_t  right_q;
   ssd_sample_t  right_d;
   logic         upd_q;
   logic         upd_d;

   // Strobes are decoded once here and shared by the groups below.
   assign rise       = ce_i & bclk_s & ~bclk_prev_q;
   assign csel_edge  = rise & seen_q & (csel_s != csel_q);
   assign ends_left  = csel_edge & (chan_of(csel_q) == SSD_CH_LEFT);
   assign ends_right = csel_edge & (chan_of(csel_q) == SSD_CH_RIGHT);
   assign fire       = rise & pend_q & (cnt_q == UPD_LAST);

   always_comb begin
      bclk_prev_d = bclk_prev_q;
      if (ce_i) begin
         bclk_prev_d = bclk_s;
      end
   end

   // Resets to the idle level of the pin, so no false rise follows reset.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         bclk_prev_q <= 1'b0;
      end else begin
         bclk_prev_q <= bclk_prev_d;
      end
   end

   always_comb begin
      shift_d = shift_q;
      csel_d  = csel_q;
      seen_d  = seen_q;
      if (rise) begin
         // The newest bit enters at the bottom, so the MSB ends on top.
         shift_d = {shift_q[`SSD_SAMPLE_W-2:0], sdata_s};
         csel_d  = csel_s;
         seen_d  = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         shift_q <= `SSD_SAMPLE_RST;
         csel_q  <= 1'b0;
         seen_q  <= 1'b0;
      end else begin
         shift_q <= shift_d;
         csel_q  <= csel_d;
         seen_q  <= seen_d;
      end
   end

   always_comb begin
      left_stage_d  = left_stage_q;
      right_stage_d = right_stage_q;
      // The bit sampled with the select change belongs to the next word, so the old shift holds the sample.
      if (ends_left) begin
         left_stage_d = shift_q;
      end
      // A left ending only stages its word; it never starts an update.
      if (ends_right) begin
         right_stage_d = shift_q;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         left_stage_q  <= `SSD_SAMPLE_RST;
         right_stage_q <= `SSD_SAMPLE_RST;
      end else begin
         left_stage_q  <= left_stage_d;
         right_stage_q <= right_stage_d;
      end
   end

   always_comb begin
      pend_d = pend_q;
      cnt_d  = cnt_q;
      if (rise && pend_q) begin
         // Only bit-clock edges advance the wait, so a stopped clock never updates.
         if (fire) begin
            pend_d = 1'b0;
         end else begin
            cnt_d = cnt_q + ssd_upd_cnt_t'(1);
         end
      end
      // A new right ending restarts the wait and wins over a clear in the same cycle.
      if (ends_right) begin
         pend_d = 1'b1;
         cnt_d  = '0;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         pend_q <= 1'b0;
         cnt_q  <= '0;
      end else begin
         pend_q <= pend_d;
         cnt_q  <= cnt_d;
      end
   end

   // Both outputs load only on fire, so the two channels change in the same cycle.
   always_comb begin
      left_d  = left_q;
      right_d = right_q;
      upd_d   = 1'b0;
      if (fire) begin
         left_d  = left_stage_q;
         right_d = right_stage_q;
         upd_d   = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         left_q  <= `SSD_SAMPLE_RST;
         right_q <= `SSD_SAMPLE_RST;
         upd_q   <= 1'b0;
      end else begin
         left_q  <= left_d;
         right_q <= right_d;
         upd_q   <= upd_d;
      end
   end

   assign left_sample_o  = left_q;
   assign right_sample_o = right_q;
   assign update_o       = upd_q;

endmodule // ssd_input

// ===== verif/ssd_host.sv
// Behavioural host that drives bit clock, serial data and channel select.
// Assumes mclk_i is the system clock; the bit clock lasts eight mclk cycles.
`timescale 1ns/1ps
module ssd_host (
   input  wire logic mclk_i,
   output logic      bclk_o,
   output logic      sd_o,
   output logic      sel_o
);
   initial begin
      bclk_o = 0;
      sd_o = 0;
      sel_o = 0;
   end
   // Data and select move only while the bit clock is low.
   task automatic tick(input logic d);
      sd_o = d;
      repeat (4) @(negedge mclk_i);
      bclk_o = 1;
      repeat (4) @(negedge mclk_i);
      bclk_o = 0;
   endtask
   // Select moves on the falling edge after the previous LSB.
   task automatic word(input logic [15:0] w, input logic s, input int pre);
      sel_o = s;
      for (int i = 0; i < pre + 16; i++) tick(i < pre ? ~w[0] : w[15 - (i - pre)]);
   endtask
   // Gated clock: select moves with no clock, data no longer holds its level.
   task automatic stop(input logic s);
      sel_o = s;
      sd_o = ~sd_o;
   endtask
endmodule // ssd_host

// ===== verif/ssd_input_assertions.sv
// Checker for the serial converter input block.
// Assumes it is bound to ssd_input and sees only its ports.
`timescale 1ns/1ps
`include "ssd_map.svh"
module ssd_input_assertions
   import ssd_pkg::*;
#(
   parameter logic LEFT_LEVEL = `SSD_LEFT_LEVEL_DFLT
) (
   input wire logic        mclk_i,
   input wire logic        reset_i,
   input wire logic        ce_i,
   input wire logic        bit_clk_i,
   input wire logic        serial_data_i,
   input wire logic        channel_select_i,
   input wire ssd_sample_t left_sample_o,
   input wire ssd_sample_t right_sample_o,
   input wire logic        update_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   upd_gap_a: assert property (update_o |=> !update_o [*8]) else $error("update too soon");
   out_sync_a: assert property (($changed(left_sample_o) || $changed(right_sample_o)) |-> update_o)
      else $error("output moved alone");
   upd_edge_a: assert property ($rose(update_o) |-> $past(bit_clk_i, 3) && !$past(bit_clk_i, 4))
      else $error("update off clock rise");
   no_clk_a: assert property ($stable(bit_clk_i) [*8] |=> !update_o) else $error("update with no clock");
   rst_zero_a: assert property (disable iff (1'b0) reset_i |=>
      left_sample_o == 16'h0000 && right_sample_o == 16'h0000 && !update_o) else $error("bad reset output");
   upd_left_a: assert property (update_o |-> channel_select_i == LEFT_LEVEL)
      else $error("update outside left period");
endmodule // ssd_input_assertions
bind ssd_input ssd_input_assertions #(.LEFT_LEVEL(LEFT_LEVEL)) ssd_input_assertions_i (.mclk_i(mclk_i),
   .reset_i(reset_i),
   .ce_i(ce_i), .bit_clk_i(bit_clk_i), .serial_data_i(serial_data_i), .channel_select_i(channel_select_i),
   .left_sample_o(left_sample_o), .right_sample_o(right_sample_o), .update_o(update_o));

// ===== verif/ssd_input_test.sv
// Testbench for the serial converter input block.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
module ssd_input_test;
   import ssd_pkg::*;
   logic        mclk_i, reset_i, ce_i, bit_clk, serial_data, channel_select, update;
   ssd_sample_t left_sample, right_sample;
   int          error_cnt = 0;
   int          n_tests = 0;
   ssd_input ssd_input_i (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .bit_clk_i(bit_clk),
      .serial_data_i(serial_data), .channel_select_i(channel_select), .left_sample_o(left_sample),
      .right_sample_o(right_sample), .update_o(update));
   ssd_host ssd_host_i (.mclk_i(mclk_i), .bclk_o(bit_clk), .sd_o(serial_data), .sel_o(channel_select));
   initial begin
      mclk_i = 0;
      forever #25 mclk_i = ~mclk_i;
   end
   task automatic final_report();
      $display("errors %0d tests %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // A missing update ends the run, since later scenarios build on it.
   task automatic expect_out(input logic upd, input ssd_sample_t l, input ssd_sample_t r);
      logic seen;
      seen = 0;
      for (int i = 0; i < 300 && !seen; i++) begin
         @(negedge mclk_i);
         seen = (update === 1'b1);
      end
      n_tests++;
      if (seen !== upd || left_sample !== l || right_sample !== r) begin
         error_cnt++;
         $display("[ERR] %0t output mismatch", $time);
         if (upd && !seen) final_report();
      end
   endtask
   task automatic t_free();
      ssd_host_i.word(16'h7FFF, SSD_CH_LEFT, 2);
      ssd_host_i.word(16'h8000, SSD_CH_RIGHT, 0);
      fork
         ssd_host_i.word(16'h1234, SSD_CH_LEFT, 0);
         expect_out(1, 16'h7FFF, 16'h8000);
      join
   endtask
   task automatic t_gated();
      ssd_host_i.word(16'h0000, SSD_CH_RIGHT, 0);
      ssd_host_i.stop(SSD_CH_LEFT);
      expect_out(0, 16'h7FFF, 16'h8000);
      fork
         ssd_host_i.word(16'hFFFF, SSD_CH_LEFT, 0);
         expect_out(1, 16'h1234, 16'h0000);
      join
   endtask
   // Used at start and again mid-run, when the outputs hold a nonzero word.
   task automatic t_reset();
      reset_i = 1;
      repeat (3) @(negedge mclk_i);
      reset_i = 0;
      expect_out(0, 16'h0000, 16'h0000);
   endtask
   // After reset the first rise only records the select level.
   task automatic t_restart();
      ssd_host_i.word(16'h4321, SSD_CH_LEFT, 0);
      ssd_host_i.word(16'h8001, SSD_CH_RIGHT, 0);
      fork
         ssd_host_i.word(16'h0001, SSD_CH_LEFT, 0);
         expect_out(1, 16'h4321, 16'h8001);
      join
   endtask
   initial begin
      ce_i = 1;
      t_reset();
      t_free();
      t_gated();
      t_reset();
      t_restart();
      final_report();
   end
endmodule // ssd_input_test
